// ---- rtl/sfc_pkg.sv ----
// Shared constants, types and decoders of the serial flash command front end
package sfc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam int unsigned ADDR_W         = 24;
   localparam int unsigned LANES          = 4;
   localparam int unsigned CNT_W          = 5;

   // Reset values of the synchronised pins: HOLD_N, CS_N, SCLK, IO3..IO0
   localparam logic [6:0]  PIN_RST_VAL    = 7'h60;

   // Serial clocks of the dummy phase per read opcode
   localparam logic [3:0]  DUMMY_NONE     = 4'h0;
   localparam logic [3:0]  DUMMY_DUAL_IO  = 4'h4;
   localparam logic [3:0]  DUMMY_QUAD_IO  = 4'h6;
   localparam logic [3:0]  DUMMY_STD      = 4'h8;

   // Array read, program and erase opcodes, plus write latch and status write opcodes
   localparam logic [7:0]  READ_CMD              = 8'h03;
   localparam logic [7:0]  FAST_READ_CMD         = 8'h0B;
   localparam logic [7:0]  DUAL_IO_READ_CMD      = 8'hBB;
   localparam logic [7:0]  DUAL_OUT_READ_CMD     = 8'h3B;
   localparam logic [7:0]  QUAD_IO_READ_CMD      = 8'hEB;
   localparam logic [7:0]  QUAD_OUT_READ_CMD     = 8'h6B;
   localparam logic [7:0]  PARAM_TABLE_READ_CMD  = 8'h5A;
   localparam logic [7:0]  PAGE_PROG_CMD         = 8'h02;
   localparam logic [7:0]  QUAD_PAGE_PROG_CMD    = 8'h38;
   localparam logic [7:0]  SECTOR_ERASE_CMD      = 8'h20;
   localparam logic [7:0]  HALF_BLOCK_ERASE_CMD  = 8'h52;
   localparam logic [7:0]  BLOCK_ERASE_CMD       = 8'hD8;
   localparam logic [7:0]  CHIP_ERASE_CMD        = 8'h60;
   localparam logic [7:0]  CHIP_ERASE_ALT_CMD    = 8'hC7;
   localparam logic [7:0]  WRITE_LATCH_SET_CMD   = 8'h06;
   localparam logic [7:0]  WRITE_LATCH_CLEAR_CMD = 8'h04;
   localparam logic [7:0]  STATUS_WRITE_CMD      = 8'h01;

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_CMD     = 3'h1,
      ST_ADDR    = 3'h2,
      ST_DUMMY   = 3'h3,
      ST_DIN     = 3'h4,
      ST_DOUT    = 3'h5,
      ST_END     = 3'h6,
      ST_STANDBY = 3'h7
   } sfc_state_e;

   typedef enum logic [2:0] {
      CL_UNKNOWN    = 3'h0,
      CL_READ_ADDR  = 3'h1,
      CL_READ_REG   = 3'h2,
      CL_CTRL       = 3'h3,
      CL_ERASE_ADDR = 3'h4,
      CL_ERASE_CHIP = 3'h5,
      CL_PROG       = 3'h6,
      CL_REG_WRITE  = 3'h7
   } sfc_class_e;

   typedef struct packed {
      logic                valid;
      logic [7:0]          opcode;
      logic [ADDR_W-1:0]   addr;
   } sfc_exec_s;

   typedef struct packed {
      logic                valid;
      logic [7:0]          data;
   } sfc_byte_s;

   ////////////////////////////////////////////////////////////////////////////
   function automatic sfc_class_e cmd_class(input logic [7:0] op);
      case (op)
         8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h5A: cmd_class = CL_READ_ADDR;
         8'h05, 8'h15, 8'h9F, 8'hAB, 8'h90, 8'h2B:         cmd_class = CL_READ_REG;
         8'h06, 8'h04, 8'hB9, 8'hB1, 8'hC1, 8'h2F, 8'h75,
         8'hB0, 8'h7A, 8'h30, 8'h00, 8'h66, 8'h99:         cmd_class = CL_CTRL;
         8'h20, 8'h52, 8'hD8:                              cmd_class = CL_ERASE_ADDR;
         8'h60, 8'hC7:                                     cmd_class = CL_ERASE_CHIP;
         8'h02, 8'h38:                                     cmd_class = CL_PROG;
         8'h01, 8'hC0:                                     cmd_class = CL_REG_WRITE;
         default:                                          cmd_class = CL_UNKNOWN;
      endcase
   endfunction

   function automatic logic [2:0] addr_lanes(input logic [7:0] op);
      case (op)
         DUAL_IO_READ_CMD: addr_lanes = 3'h2;
         QUAD_IO_READ_CMD: addr_lanes = 3'h4;
         default:          addr_lanes = 3'h1;
      endcase
   endfunction

   function automatic logic [2:0] data_lanes(input logic [7:0] op);
      case (op)
         DUAL_IO_READ_CMD, DUAL_OUT_READ_CMD:                    data_lanes = 3'h2;
         QUAD_IO_READ_CMD, QUAD_OUT_READ_CMD, QUAD_PAGE_PROG_CMD: data_lanes = 3'h4;
         default:                                                data_lanes = 3'h1;
      endcase
   endfunction

   function automatic logic [3:0] dummy_clocks(input logic [7:0] op);
      case (op)
         READ_CMD:         dummy_clocks = DUMMY_NONE;
         DUAL_IO_READ_CMD: dummy_clocks = DUMMY_DUAL_IO;
         QUAD_IO_READ_CMD: dummy_clocks = DUMMY_QUAD_IO;
         default:          dummy_clocks = DUMMY_STD;
      endcase
   endfunction

   function automatic logic is_write_type(input sfc_class_e cl);
      is_write_type = (cl == CL_ERASE_ADDR) || (cl == CL_ERASE_CHIP) ||
                      (cl == CL_PROG) || (cl == CL_REG_WRITE);
   endfunction

endpackage

// ---- rtl/sfc_pin_sync.sv ----
// Two-flop synchronisers with edge detection for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module sfc_pin_sync #(
   parameter int unsigned W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);

   ////////////////////////////////////////////////////////////////////////////
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_r;
         logic sync_r;
         logic prev_r;
         // The third flop only feeds the edge detector, so the metastable
         // first stage is never seen by logic
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_r <= RST_VAL[i];
               sync_r <= RST_VAL[i];
               prev_r <= RST_VAL[i];
            end else begin
               meta_r <= d[i];
               sync_r <= meta_r;
               prev_r <= sync_r;
            end
         end
         assign q[i]    = sync_r;
         assign rise[i] = sync_r & ~prev_r;
         assign fall[i] = ~sync_r & prev_r;
      end
   endgenerate

endmodule
`default_nettype wire

// ---- rtl/sfc_front_end.sv ----
// Serial command front end: framing, hold, opcode decode and data shifting
`timescale 1ns/1ps
`default_nettype none
module sfc_front_end (
   input  wire logic                        REF_CLK,
   input  wire logic                        RST_N,
   input  wire logic                        SCLK,
   input  wire logic                        CS_N,
   input  wire logic                        HOLD_N,
   input  wire logic [3:0]                  IO_IN,
   output logic      [3:0]                  IO_OUT,
   output logic      [3:0]                  IO_OE_N,
   input  wire logic                        QUAD_MODE,
   input  wire logic                        BUSY,
   input  wire logic [7:0]                  RD_DATA,
   input  wire logic [7:0]                  REG_DATA,
   output logic      [sfc_pkg::ADDR_W-1:0]  RD_ADDR,
   output sfc_pkg::sfc_exec_s               EXEC,
   output sfc_pkg::sfc_byte_s               DIN,
   output logic                             WRITE_LATCH,
   output logic                             ACTIVE,
   output logic                             PAUSED
);

   ////////////////////////////////////////////////////////////////////////////
   logic [6:0]                    pin_q;
   logic [6:0]                    pin_rise;
   logic [6:0]                    pin_fall;
   logic                          hold_n_s;
   logic                          cs_n_s;
   logic                          sck_s;
   logic [3:0]                    io_s;
   logic                          cs_fall;
   logic                          cs_rise;
   logic                          sck_rise;
   logic                          sck_fall;

   sfc_pin_sync #(
      .W       (7),
      .RST_VAL (sfc_pkg::PIN_RST_VAL)
   ) u_sync (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .d     ({HOLD_N, CS_N, SCLK, IO_IN}),
      .q     (pin_q),
      .rise  (pin_rise),
      .fall  (pin_fall)
   );

   assign hold_n_s = pin_q[6];
   assign cs_n_s   = pin_q[5];
   assign sck_s    = pin_q[4];
   assign io_s     = pin_q[3:0];
   assign cs_fall  = pin_fall[5];
   assign cs_rise  = pin_rise[5];
   // Edges are found from the sampled clock alone, so idle level does not matter
   assign sck_rise = pin_rise[4];
   assign sck_fall = pin_fall[4];

   function automatic logic [sfc_pkg::ADDR_W-1:0] shift_in(
      input logic [sfc_pkg::ADDR_W-1:0] sh,
      input logic [2:0]                 w,
      input logic [3:0]                 bits
   );
      case (w)
         3'h2:    shift_in = {sh[sfc_pkg::ADDR_W-3:0], bits[1:0]};
         3'h4:    shift_in = {sh[sfc_pkg::ADDR_W-5:0], bits};
         default: shift_in = {sh[sfc_pkg::ADDR_W-2:0], bits[0]};
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pause tracking
   logic hold_r;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         hold_r <= 1'b0;
      end else if (cs_n_s || QUAD_MODE) begin
         hold_r <= 1'b0;
      end else if (!hold_r && !hold_n_s && !sck_s) begin
         hold_r <= 1'b1;
      end else if (hold_r && hold_n_s && !sck_s) begin
         hold_r <= 1'b0;
      end
   end

   // Sampling edges are simply not taken while paused
   logic take;
   assign take = sck_rise && !hold_r && !cs_n_s;

   ////////////////////////////////////////////////////////////////////////////
   // Command sequencer
   sfc_pkg::sfc_state_e            state_r;
   sfc_pkg::sfc_class_e            class_r;
   logic [7:0]                     op_r;
   logic [sfc_pkg::ADDR_W-1:0]     sh_r;
   logic [sfc_pkg::ADDR_W-1:0]     addr_r;
   logic [sfc_pkg::CNT_W-1:0]      cnt_r;
   logic [2:0]                     addr_w_r;
   logic [2:0]                     data_w_r;
   logic [3:0]                     dummy_r;
   logic                           din_seen_r;
   logic                           wl_r;

   logic [7:0]                     op_in;
   sfc_pkg::sfc_class_e            class_in;
   logic                           array_access;
   logic                           reject;
   logic [sfc_pkg::ADDR_W-1:0]     sh_nxt;
   logic [sfc_pkg::CNT_W-1:0]      cnt_step;

   assign op_in        = {sh_r[6:0], io_s[0]};
   assign class_in     = sfc_pkg::cmd_class(op_in);
   assign array_access = (class_in == sfc_pkg::CL_READ_ADDR) || (class_in == sfc_pkg::CL_PROG) ||
                         (class_in == sfc_pkg::CL_ERASE_ADDR) || (class_in == sfc_pkg::CL_ERASE_CHIP);
   assign reject       = (class_in == sfc_pkg::CL_UNKNOWN)
                      || (sfc_pkg::is_write_type(class_in) && !wl_r)
                      || (array_access && BUSY);
   assign sh_nxt       = shift_in(sh_r, (state_r == sfc_pkg::ST_ADDR) ? addr_w_r : data_w_r, io_s);
   assign cnt_step     = cnt_r + sfc_pkg::CNT_W'((state_r == sfc_pkg::ST_ADDR) ? addr_w_r : data_w_r);

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_r    <= sfc_pkg::ST_IDLE;
         class_r    <= sfc_pkg::CL_UNKNOWN;
         op_r       <= 8'h00;
         sh_r       <= '0;
         addr_r     <= '0;
         cnt_r      <= '0;
         addr_w_r   <= 3'h1;
         data_w_r   <= 3'h1;
         dummy_r    <= 4'h0;
         din_seen_r <= 1'b0;
      end else if (cs_n_s) begin
         // Chip select high, including a rise during a pause, returns the sequencer to idle and clears its count and data flag
         state_r    <= sfc_pkg::ST_IDLE;
         cnt_r      <= '0;
         din_seen_r <= 1'b0;
      end else if (cs_fall || state_r == sfc_pkg::ST_IDLE) begin
         state_r    <= sfc_pkg::ST_CMD;
         sh_r       <= '0;
         cnt_r      <= '0;
         din_seen_r <= 1'b0;
      end else if (take) begin
         case (state_r)
            sfc_pkg::ST_CMD: begin
               sh_r  <= {sh_r[sfc_pkg::ADDR_W-2:0], io_s[0]};
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == 5'h07) begin
                  op_r     <= op_in;
                  class_r  <= class_in;
                  addr_w_r <= sfc_pkg::addr_lanes(op_in);
                  data_w_r <= sfc_pkg::data_lanes(op_in);
                  dummy_r  <= sfc_pkg::dummy_clocks(op_in);
                  cnt_r    <= '0;
                  if (reject) begin
                     state_r <= sfc_pkg::ST_STANDBY;
                  end else begin
                     case (class_in)
                        sfc_pkg::CL_READ_ADDR,
                        sfc_pkg::CL_ERASE_ADDR,
                        sfc_pkg::CL_PROG:       state_r <= sfc_pkg::ST_ADDR;
                        sfc_pkg::CL_READ_REG:   state_r <= sfc_pkg::ST_DOUT;
                        sfc_pkg::CL_REG_WRITE:  state_r <= sfc_pkg::ST_DIN;
                        default:                state_r <= sfc_pkg::ST_END;
                     endcase
                  end
               end
            end
            sfc_pkg::ST_ADDR: begin
               sh_r  <= sh_nxt;
               cnt_r <= cnt_step;
               if (cnt_step == 5'(sfc_pkg::ADDR_W)) begin
                  addr_r <= sh_nxt;
                  cnt_r  <= '0;
                  case (class_r)
                     sfc_pkg::CL_READ_ADDR:
                        state_r <= (dummy_r == sfc_pkg::DUMMY_NONE) ? sfc_pkg::ST_DOUT
                                                                    : sfc_pkg::ST_DUMMY;
                     sfc_pkg::CL_PROG: state_r <= sfc_pkg::ST_DIN;
                     default:          state_r <= sfc_pkg::ST_END;
                  endcase
               end
            end
            sfc_pkg::ST_DUMMY: begin
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r + 5'h01 == {1'b0, dummy_r}) begin
                  cnt_r   <= '0;
                  state_r <= sfc_pkg::ST_DOUT;
               end
            end
            sfc_pkg::ST_DIN: begin
               sh_r  <= sh_nxt;
               cnt_r <= cnt_step;
               if (cnt_step == 5'h08) begin
                  cnt_r      <= '0;
                  din_seen_r <= 1'b1;
               end
            end
            sfc_pkg::ST_END: begin
               // Extra clocks only move the byte boundary
               cnt_r <= (cnt_r == 5'h07) ? 5'h00 : cnt_r + 5'h01;
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Completion of write-type and control commands at chip select rise
   logic finish_ok;
   assign finish_ok = cs_rise && !hold_r && (cnt_r == 5'h00) &&
                      ((state_r == sfc_pkg::ST_END) || (state_r == sfc_pkg::ST_DIN && din_seen_r));

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         EXEC <= '0;
      end else begin
         EXEC.valid  <= finish_ok;
         EXEC.opcode <= finish_ok ? op_r : EXEC.opcode;
         EXEC.addr   <= finish_ok ? addr_r : EXEC.addr;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         DIN <= '0;
      end else begin
         DIN.valid <= take && state_r == sfc_pkg::ST_DIN && cnt_step == 5'h08;
         DIN.data  <= (take && state_r == sfc_pkg::ST_DIN) ? sh_nxt[7:0] : DIN.data;
      end
   end

   // Latch is consumed by each write-type command that executes
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         wl_r <= 1'b0;
      end else if (finish_ok) begin
         if (op_r == sfc_pkg::WRITE_LATCH_SET_CMD) begin
            wl_r <= 1'b1;
         end else if (op_r == sfc_pkg::WRITE_LATCH_CLEAR_CMD || sfc_pkg::is_write_type(class_r)) begin
            wl_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ACTIVE      <= 1'b0;
         PAUSED      <= 1'b0;
         WRITE_LATCH <= 1'b0;
      end else begin
         ACTIVE      <= !cs_n_s && state_r != sfc_pkg::ST_IDLE && state_r != sfc_pkg::ST_CMD &&
                        state_r != sfc_pkg::ST_STANDBY;
         PAUSED      <= hold_r;
         WRITE_LATCH <= wl_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output shifter, updated on serial clock falls
   logic [7:0]                 out_sh_r;
   logic [3:0]                 ocnt_r;
   logic [sfc_pkg::ADDR_W-1:0] idx_r;
   logic [3:0]                 lane_val_r;
   logic [7:0]                 src_byte;
   logic [7:0]                 cur_byte;
   logic                       load;
   logic                       shift_out;

   assign src_byte  = (class_r == sfc_pkg::CL_READ_REG) ? REG_DATA : RD_DATA;
   assign shift_out = sck_fall && !hold_r && !cs_n_s && state_r == sfc_pkg::ST_DOUT;
   assign load      = ocnt_r == 4'h0;
   assign cur_byte  = load ? src_byte : out_sh_r;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         out_sh_r   <= 8'h00;
         ocnt_r     <= 4'h0;
         idx_r      <= '0;
         lane_val_r <= 4'h0;
      end else if (state_r != sfc_pkg::ST_DOUT) begin
         ocnt_r <= 4'h0;
         idx_r  <= '0;
      end else if (shift_out) begin
         case (data_w_r)
            3'h2: begin
               lane_val_r <= {2'b00, cur_byte[7:6]};
               out_sh_r   <= {cur_byte[5:0], 2'b00};
            end
            3'h4: begin
               lane_val_r <= cur_byte[7:4];
               out_sh_r   <= {cur_byte[3:0], 4'h0};
            end
            default: begin
               lane_val_r <= {2'b00, cur_byte[7], 1'b0};
               out_sh_r   <= {cur_byte[6:0], 1'b0};
            end
         endcase
         ocnt_r <= (load ? 4'h8 : ocnt_r) - {1'b0, data_w_r};
         if (load) begin
            idx_r <= idx_r + 24'h000001;
         end
      end
   end

   // Address for the next byte; the array answers well before the next fall
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         RD_ADDR <= '0;
      end else begin
         RD_ADDR <= addr_r + idx_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drivers; enables are active low, single line output goes out on IO1
   logic       drive;
   logic [3:0] lane_en;

   assign drive   = state_r == sfc_pkg::ST_DOUT && !cs_n_s && ocnt_r != 4'h0 || 
                    state_r == sfc_pkg::ST_DOUT && !cs_n_s && idx_r != '0;
   assign lane_en = (data_w_r == 3'h4) ? 4'hF : (data_w_r == 3'h2) ? 4'h3 : 4'h2;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         IO_OUT  <= 4'h0;
         IO_OE_N <= 4'hF;
      end else begin
         IO_OUT <= lane_val_r;
         // Outside QUAD_MODE, pause input low floats the output at once, even before the pause begins
         if (drive && (hold_n_s || QUAD_MODE) && !hold_r) begin
            IO_OE_N <= ~lane_en;
         end else begin
            IO_OE_N <= 4'hF;
         end
      end
   end

endmodule
`default_nettype wire

// ---- tb/sfc_host_model.sv ----
// Behavioural serial bus master for the front end link
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model (
   output logic            sclk = 1'b0,
   output logic            cs_n = 1'b1,
   output logic            hold_n = 1'b1,
   output logic [3:0]      io_in = 4'hF,
   input  wire logic [3:0] io_out,
   input  wire logic [3:0] io_oe_n
);
   logic cpol = 1'b0;
   // Clock parks first, so no stray edge lands inside the frame
   // Pins change by non-blocking assignment, so the synchroniser never races them
   task automatic sel(input logic on);
      sclk <= cpol;
      #160 cs_n <= !on;
      io_in[0] <= !io_in[0];
      #320;
   endtask
   // Capture late in the high phase; a released line reads as its pull-up
   task automatic bits(input logic [39:0] v, input int n, output logic [39:0] r);
      r = '0;
      for (int i = n - 1; i >= 0; i--) begin
         sclk <= 1'b0;
         io_in[0] <= v[i];
         #160 sclk <= 1'b1;
         #160 r = {r[38:0], io_oe_n[1] ? 1'b1 : io_out[1]};
      end
   endtask
   task automatic hold(input logic on);
      sclk <= 1'b0;
      #80 hold_n <= !on;
      #480;
   endtask
endmodule
`default_nettype wire

// ---- tb/sfc_front_end_chk.sv ----
// Port checks of the serial flash command front end
`timescale 1ns/1ps
`default_nettype none
module sfc_front_end_chk (
   input wire logic               REF_CLK,
   input wire logic               RST_N,
   input wire logic               CS_N,
   input wire logic               HOLD_N,
   input wire logic [3:0]         IO_OE_N,
   input wire sfc_pkg::sfc_exec_s EXEC,
   input wire sfc_pkg::sfc_byte_s DIN,
   input wire logic               WRITE_LATCH,
   input wire logic               ACTIVE,
   input wire logic               PAUSED
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   hold_oe_a: assert property (PAUSED |-> &IO_OE_N) else $error("driven in pause");
   hold_on_a: assert property ($rose(PAUSED) |-> !$past(HOLD_N, 2) && !$past(CS_N, 2)) else $error("bad pause");
   hold_off_a: assert property ($fell(PAUSED) |-> $past(HOLD_N, 2) || $past(CS_N, 2)) else $error("bad resume");
   exec_cs_a: assert property (EXEC.valid |-> CS_N) else $error("early exec");
   latch_set_a: assert property (EXEC.valid && EXEC.opcode == 8'h06 |=> WRITE_LATCH) else $error("no latch");
   din_latch_a: assert property (DIN.valid |-> WRITE_LATCH && ACTIVE) else $error("data unlatched");
   act_end_a: assert property (CS_N [*6] |-> !ACTIVE) else $error("active idle");
   idle_oe_a: assert property (!ACTIVE [*6] |-> &IO_OE_N) else $error("driven idle");
   cover property ($rose(PAUSED));
   cover property (DIN.valid);
   cover property (EXEC.valid);
endmodule
bind sfc_front_end sfc_front_end_chk i_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .CS_N(CS_N), .HOLD_N(HOLD_N),
   .IO_OE_N(IO_OE_N), .EXEC(EXEC), .DIN(DIN), .WRITE_LATCH(WRITE_LATCH), .ACTIVE(ACTIVE), .PAUSED(PAUSED));
`default_nettype wire

// ---- tb/tb_sfc_front_end.sv ----
// Self-checking bench for the serial flash command front end
`timescale 1ns/1ps
`default_nettype none
module tb_sfc_front_end;
   logic               ref_clk = 1'b0, rst_n = 1'b0, sclk, cs_n, hold_n, wr_latch, active, paused;
   logic               quad_mode = 1'b0, busy = 1'b0;
   logic [3:0]         io_in, io_out, io_oe_n;
   logic [7:0]         rd_data = 8'h00, reg_data = 8'h00, last_d;
   logic [23:0]        rd_addr;
   logic [39:0]        r;
   sfc_pkg::sfc_exec_s exec, last_x;
   sfc_pkg::sfc_byte_s din;
   int                 errors = 0, n_compared = 0, n_exec = 0;
   always #20 ref_clk = ~ref_clk;
   // Array byte follows the address so each streamed byte is predictable
   always @(posedge ref_clk) rd_data <= rd_addr[7:0] + 8'h3C;
   always @(posedge ref_clk) if (exec.valid) n_exec <= n_exec + 1;
   always @(posedge ref_clk) if (exec.valid) last_x <= exec;
   always @(posedge ref_clk) if (din.valid) last_d <= din.data;
   sfc_front_end i_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .HOLD_N(hold_n), .IO_IN(io_in),
      .IO_OUT(io_out), .IO_OE_N(io_oe_n), .QUAD_MODE(quad_mode), .BUSY(busy), .RD_DATA(rd_data),
      .REG_DATA(reg_data), .RD_ADDR(rd_addr), .EXEC(exec), .DIN(din), .WRITE_LATCH(wr_latch), .ACTIVE(active),
      .PAUSED(paused));
   sfc_host_model h (.sclk(sclk), .cs_n(cs_n), .hold_n(hold_n), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n));
   task automatic check(input string s, input logic [39:0] seen, exp);
      n_compared++;
      if (seen !== exp) errors++;
      if (seen !== exp) $display("mismatch %s expected %h seen %h", s, exp, seen);
   endtask
   task automatic frame(input logic [39:0] v, input int n);
      h.sel(1'b1);
      h.bits(v, n, r);
      h.sel(1'b0);
   endtask
   task automatic t_write;
      frame(40'h06, 8);
      check("latch", wr_latch, 1'b1);
      frame({8'h02, 24'h123456, 8'hA5}, 40);
      check("program", {last_x.opcode, last_x.addr, last_d}, {8'h02, 24'h123456, 8'hA5});
      frame(40'h06, 8);
      frame({8'h20, 24'h0, 3'h0}, 35);
      frame(40'h04, 8);
      h.sel(1'b1);
      h.bits({8'h20, 24'h0}, 32, r);
      check("refused", {active, io_oe_n, wr_latch}, 6'h1E);
      h.sel(1'b0);
      check("execs", n_exec, 40'h4);
   endtask
   task automatic t_read;
      for (int m = 0; m < 2; m++) begin
         h.cpol = m[0];
         h.sel(1'b1);
         h.bits({8'h03, 24'h000010}, 32, r);
         check("active", active, 1'b1);
         h.bits(40'h0, 8, r);
         check("byte0", r, 40'h4C);
         h.hold(1'b1);
         check("pause", {paused, io_oe_n}, 5'h1F);
         h.bits(40'hFF, 8, r);
         h.hold(1'b0);
         h.bits(40'h0, 8, r);
         check("byte1", r, 40'h4D);
         h.sel(1'b0);
      end
   endtask
   // Status poll, array read while busy, pause attempt in four-line mode
   task automatic t_gate;
      reg_data <= 8'hC3;
      h.sel(1'b1);
      h.bits(40'h05, 8, r);
      h.bits(40'h0, 8, r);
      check("status", r, 40'hC3);
      h.sel(1'b0);
      busy <= 1'b1;
      h.sel(1'b1);
      h.bits({8'h03, 24'h000010, 8'h00}, 40, r);
      check("busy", {active, r[7:0]}, 9'h0FF);
      h.sel(1'b0);
      busy <= 1'b0;
      quad_mode <= 1'b1;
      h.sel(1'b1);
      h.bits({8'h03, 24'h000010}, 32, r);
      h.bits(40'h0, 8, r);
      h.hold(1'b1);
      check("quad", {paused, io_oe_n}, 5'h0D);
      h.hold(1'b0);
      h.sel(1'b0);
      quad_mode <= 1'b0;
   endtask
   task automatic finish_test;
      if (errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #1000000 errors++;
      finish_test;
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_write;
      t_read;
      t_gate;
      finish_test;
   end
endmodule
`default_nettype wire
